// [shared/hnbt_pkg.sv]
// Purpose: shared constants for the nibble bus target and host ends
// Assumes: one clock mclk at 100 MHz for both ends
// Notes:   field codes and cycle positions of the single-byte cycle
package hnbt_pkg;
  // ==========================================================
  // field codes
  localparam logic [3:0] START_READ  = 4'hd;
  localparam logic [3:0] START_WRITE = 4'he;
  localparam logic [3:0] SIZE_ONE    = 4'h0;
  localparam logic [3:0] TAR_ONES    = 4'hf;
  localparam logic [3:0] SYNC_READY  = 4'h0;
  localparam logic [3:0] ABORT_CODE  = 4'hf;
  // ==========================================================
  // cycle layout (clock numbers, start field is clock 1)
  localparam logic [4:0] CLK_SEL     = 5'h02;
  localparam logic [4:0] CLK_ADDR_LO = 5'h03;
  localparam logic [4:0] CLK_ADDR_HI = 5'h09;
  localparam logic [4:0] CLK_SIZE    = 5'h0a;
  localparam logic [4:0] CLK_WDAT_LO = 5'h0b;
  localparam logic [4:0] CLK_WDAT_HI = 5'h0c;
  localparam logic [4:0] CLK_READY_SYNC_FIELD   = 5'h0d;
  localparam logic [4:0] CLK_RDAT_LO = 5'h0e;
  localparam logic [4:0] CLK_RDAT_HI = 5'h0f;
  localparam logic [4:0] CLK_WSYNC   = 5'h0f;
  localparam logic [4:0] CLK_TAR_END = 5'h10;
  localparam logic [4:0] CLK_LAST    = 5'h11;
  // ==========================================================
  // address decode: last five nibbles, space select bit
  localparam int ADDR_W      = 28;
  localparam int DEC_W       = 20;
  localparam int SPACE_BIT   = 22;
endpackage

// [shared/hnbt_if.sv]
// Purpose: five-signal nibble bus between host and target
// Assumes: both ends clocked by the same mclk
// Notes:   wire level resolved from enables; floats read as ones
`timescale 1ns/10ps
interface hnbt_if;
  logic       frame_strobe_n;
  logic [3:0] host_nibble_out;
  logic       host_nibble_oe;
  logic [3:0] targ_nibble_out;
  logic       targ_nibble_oe;
  logic [3:0] nibble_bus;
  // ==========================================================
  // wire resolution, pull-up when nobody drives
  assign nibble_bus = host_nibble_oe ? host_nibble_out :
                      targ_nibble_oe ? targ_nibble_out : 4'hf;
  modport host (output frame_strobe_n, output host_nibble_out, output host_nibble_oe,
                input nibble_bus);
  modport target (input frame_strobe_n, output targ_nibble_out, output targ_nibble_oe,
                  input nibble_bus);
endinterface

// [src/hnbt_target.sv]
// Purpose: target end of the single-byte nibble bus cycle
// Assumes: bus inputs synchronous to mclk; sequencer accepts every byte
// Notes:   write bytes go to the command sequencer as one-cycle pulses
`timescale 1ns/10ps
// Operation
// [RULE_01] five signals carry all reads and writes
// [RULE_02] strobe high and idle gives standby
// [RULE_03] strobe low, quiet bus gives ready
// [RULE_04] each field four bits, one clock
// [RULE_05] single byte transfers only
// [RULE_06] read starts 1101 with strobe low
// [RULE_07] write starts 1110, last start wins
// [RULE_08] respond only when select matches straps
// [RULE_09] seven address nibbles, msn first
// [RULE_10] size must be 0000
// [RULE_11] host drives 1111, then target owns
// [RULE_12] read sync 0000 in clock 13
// [RULE_13] data low clock 14, high 15
// [RULE_14] target 1111 at 16, host at 17
// [RULE_15] host write data low 11, high 12
// [RULE_16] write sync 0000 in clock 15
// [RULE_17] fields sampled on rising edge
// [RULE_18] write commands pass through memory writes
// [RULE_19] strobe low mid-cycle aborts, 1111 readies
// [RULE_20] bad size resets, no response
// [RULE_21] select mismatch goes to standby
// [RULE_22] decode last five nibbles, space bit
// [RULE_23] bus floats outside owned clocks
module hnbt_target (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // nibble bus
  hnbt_if.target           bus,
  // strap and memory side
  input  wire logic [3:0]  identity_strap_pins,
  input  wire logic [7:0]  rd_data,
  input  wire logic        op_busy,
  output logic             standby,
  output logic             ready,
  output logic             rd_req,
  output logic             wr_strobe,
  output logic             space_sel,
  output logic [19:0]      mem_addr,
  output logic [7:0]       wr_data
);
  typedef enum logic [2:0] {
    HNBT_IDLE  = 3'b000,
    HNBT_RUN   = 3'b001,
    HNBT_WAIT  = 3'b010,
    HNBT_SKIP  = 3'b011
  } hnbt_state_t;

  hnbt_state_t state_reg;
  hnbt_state_t state_next;
  logic [4:0]  clk_reg;
  logic        is_write_reg;
  logic [27:0] addr_reg;
  logic [7:0]  data_reg;
  logic [3:0]  out_reg;
  logic        oe_reg;

  // ==========================================================
  // field decode, sampled on the rising edge
  wire [3:0] nib       = bus.nibble_bus;                   // RULE_17
  wire       frame_low = !bus.frame_strobe_n;
  wire       is_start  = frame_low && (nib == hnbt_pkg::START_READ ||
                                       nib == hnbt_pkg::START_WRITE); // RULE_06
  wire [4:0] clk_now   = clk_reg + 5'h01;                  // clock number of this field
  wire       in_run    = state_reg == HNBT_RUN;
  // strobe low after the start clocks aborts the cycle
  wire       abort_hit = in_run && frame_low && clk_now > hnbt_pkg::CLK_SEL; // RULE_19
  wire       sel_bad   = in_run && clk_now == hnbt_pkg::CLK_SEL &&
                         nib != identity_strap_pins;       // RULE_08 RULE_21
  wire       size_bad  = in_run && clk_now == hnbt_pkg::CLK_SIZE &&
                         nib != hnbt_pkg::SIZE_ONE;        // RULE_20 RULE_05
  wire       addr_clk  = in_run && clk_now >= hnbt_pkg::CLK_ADDR_LO &&
                         clk_now <= hnbt_pkg::CLK_ADDR_HI;
  wire       wdat_lo   = in_run && is_write_reg && clk_now == hnbt_pkg::CLK_WDAT_LO;
  wire       wdat_hi   = in_run && is_write_reg && clk_now == hnbt_pkg::CLK_WDAT_HI;
  wire       cyc_done  = in_run && clk_now == hnbt_pkg::CLK_LAST;

  // ==========================================================
  // drive plan for the next clock (target owns 12..16 reads, 14..16 writes)
  wire [4:0] drv_clk   = clk_now + 5'h01;
  wire       drv_sync  = is_write_reg ? drv_clk == hnbt_pkg::CLK_WSYNC :
                                        drv_clk == hnbt_pkg::CLK_READY_SYNC_FIELD;
  wire       drv_lo    = !is_write_reg && drv_clk == hnbt_pkg::CLK_RDAT_LO;
  wire       drv_hi    = !is_write_reg && drv_clk == hnbt_pkg::CLK_RDAT_HI;
  wire       drv_tar   = drv_clk == hnbt_pkg::CLK_TAR_END;
  // second turnaround clock: take the bus one clock ahead of sync so it never floats there
  wire [4:0] own_clk   = is_write_reg ? hnbt_pkg::CLK_WSYNC - 5'h01 :
                                        hnbt_pkg::CLK_READY_SYNC_FIELD - 5'h01;
  wire       drv_own   = drv_clk == own_clk;                          // RULE_11
  wire       drv_on    = in_run && !abort_hit && !size_bad && !sel_bad &&
                         (drv_own || drv_sync || drv_lo || drv_hi || drv_tar); // RULE_23 RULE_11
  wire [3:0] drv_val   = drv_sync ? hnbt_pkg::SYNC_READY :          // RULE_12 RULE_16
                         drv_lo   ? rd_data[3:0] :                  // RULE_13
                         drv_hi   ? rd_data[7:4] :                  // RULE_13
                                    hnbt_pkg::TAR_ONES;             // RULE_14

  // ==========================================================
  // cycle state: a fresh start in clock 2 restarts, so the last one wins
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HNBT_IDLE: if (is_start) state_next = HNBT_RUN;
      HNBT_RUN: begin
        if (frame_low && clk_now == hnbt_pkg::CLK_SEL && is_start) state_next = HNBT_RUN; // RULE_07
        else if (abort_hit) state_next = HNBT_WAIT;                 // RULE_19
        else if (sel_bad) state_next = HNBT_SKIP;                   // RULE_21
        else if (size_bad || cyc_done) state_next = HNBT_IDLE;      // RULE_20
      end
      HNBT_WAIT: if (nib == hnbt_pkg::ABORT_CODE) state_next = HNBT_IDLE; // RULE_19
      HNBT_SKIP: if (is_start) state_next = HNBT_RUN;
      default:   state_next = HNBT_IDLE;
    endcase
  end

  // ==========================================================
  // state and clock counter; a start field reloads clock 1 unless a run is past clock 2
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= HNBT_IDLE;
      clk_reg      <= 5'h00;
      is_write_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (is_start && (state_reg != HNBT_RUN || clk_now == hnbt_pkg::CLK_SEL)) begin
        clk_reg      <= 5'h01;
        is_write_reg <= nib == hnbt_pkg::START_WRITE;        // RULE_07
      end else if (in_run) begin
        clk_reg <= clk_now;
      end
    end
  end

  // ==========================================================
  // address assembly msn first, and write byte low nibble first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= 28'h0000000;
      data_reg <= 8'h00;
    end else begin
      if (addr_clk) addr_reg <= {addr_reg[23:0], nib};      // RULE_09 RULE_04
      if (wdat_lo) data_reg[3:0] <= nib;                     // RULE_15
      if (wdat_hi) data_reg[7:4] <= nib;
    end
  end

  // ==========================================================
  // registered outputs; pin drive from a flop to avoid glitches
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_reg   <= 4'hf;
      oe_reg    <= 1'b0;
      rd_req    <= 1'b0;
      wr_strobe <= 1'b0;
      wr_data   <= 8'h00;
      mem_addr  <= 20'h00000;
      space_sel <= 1'b0;
      standby   <= 1'b1;
      ready     <= 1'b0;
    end else begin
      out_reg   <= drv_val;
      oe_reg    <= drv_on;                                   // RULE_23
      // read fetch after size so data is back by clock 14
      rd_req    <= in_run && !is_write_reg && clk_now == hnbt_pkg::CLK_SIZE && !size_bad;
      // byte handed to the write sequencer once both nibbles are in
      wr_strobe <= wdat_hi && !abort_hit;                    // RULE_18
      wr_data   <= {nib, data_reg[3:0]};
      if (in_run && clk_now == hnbt_pkg::CLK_ADDR_HI) begin
        mem_addr  <= {addr_reg[15:0], nib};                  // RULE_22
        space_sel <= addr_reg[hnbt_pkg::SPACE_BIT - 4];      // RULE_22
      end
      standby <= !frame_low && !op_busy && state_next != HNBT_RUN; // RULE_02
      ready   <= frame_low && state_next == HNBT_IDLE;       // RULE_03
    end
  end

  assign bus.targ_nibble_out = out_reg;                     // RULE_01
  assign bus.targ_nibble_oe  = oe_reg;
endmodule

// [src/hnbt_host.sv]
// Purpose: host end issuing single-byte read and write cycles
// Assumes: one request at a time, held until done pulses
`timescale 1ns/10ps
module hnbt_host (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // nibble bus
  hnbt_if.host             bus,
  // request side
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [3:0]  req_target,
  input  wire logic [27:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             busy,
  output logic             done,
  output logic             sync_ok,
  output logic [7:0]       rd_byte
);
  logic [4:0]  clk_reg;
  logic        wr_reg;
  logic [3:0]  tgt_reg;
  logic [27:0] addr_reg;
  logic [7:0]  wd_reg;
  logic [3:0]  out_reg;
  logic        oe_reg;
  logic        frame_reg;

  // ==========================================================
  // field for the next clock; host owns clocks 1..11 (reads) or 1..13 (writes)
  wire [4:0] nxt      = clk_reg + 5'h01;
  wire       idle     = clk_reg == 5'h00;
  wire [4:0] an       = nxt - hnbt_pkg::CLK_ADDR_LO;       // address nibble index
  wire [4:0] sh       = 5'h18 - {an[2:0], 2'b00};
  wire [27:0] ash     = addr_reg >> sh;
  wire [4:0] tar_clk  = (wr_reg ? hnbt_pkg::CLK_WSYNC : hnbt_pkg::CLK_READY_SYNC_FIELD) - 5'h02; // host 1111
  wire       own      = nxt <= tar_clk;                    // RULE_11
  wire [3:0] fld      = (nxt == hnbt_pkg::CLK_SEL)  ? tgt_reg :
                        (nxt >= hnbt_pkg::CLK_ADDR_LO && nxt <= hnbt_pkg::CLK_ADDR_HI) ?
                          ash[3:0] :                          // RULE_09
                        (nxt == hnbt_pkg::CLK_SIZE) ? hnbt_pkg::SIZE_ONE :   // RULE_10
                        (wr_reg && nxt == hnbt_pkg::CLK_WDAT_LO) ? wd_reg[3:0] : // RULE_15
                        (wr_reg && nxt == hnbt_pkg::CLK_WDAT_HI) ? wd_reg[7:4] :
                                                    hnbt_pkg::TAR_ONES;
  wire [4:0] sync_clk = wr_reg ? hnbt_pkg::CLK_WSYNC : hnbt_pkg::CLK_READY_SYNC_FIELD;

  // ==========================================================
  // sequencer and pin drive, all from flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_reg   <= 5'h00;
      wr_reg    <= 1'b0;
      tgt_reg   <= 4'h0;
      addr_reg  <= 28'h0000000;
      wd_reg    <= 8'h00;
      out_reg   <= 4'hf;
      oe_reg    <= 1'b0;
      frame_reg <= 1'b1;
      busy      <= 1'b0;
      done      <= 1'b0;
      sync_ok   <= 1'b0;
      rd_byte   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (idle) begin
        frame_reg <= 1'b1;
        oe_reg    <= 1'b0;
        if (req) begin
          // clock 1: strobe low with the start code
          clk_reg   <= 5'h01;
          wr_reg    <= req_write;
          tgt_reg   <= req_target;
          addr_reg  <= req_addr;
          wd_reg    <= req_wdata;
          frame_reg <= 1'b0;                                  // RULE_06
          oe_reg    <= 1'b1;
          out_reg   <= req_write ? hnbt_pkg::START_WRITE : hnbt_pkg::START_READ;
          busy      <= 1'b1;
          sync_ok   <= 1'b0;
        end
      end else begin
        frame_reg <= 1'b1;
        out_reg   <= fld;
        oe_reg    <= own;
        // sample target fields at the clock that carries them
        if (clk_reg == sync_clk)
          sync_ok <= bus.nibble_bus == hnbt_pkg::SYNC_READY; // RULE_12 RULE_16
        if (!wr_reg && clk_reg == hnbt_pkg::CLK_RDAT_LO) rd_byte[3:0] <= bus.nibble_bus;
        if (!wr_reg && clk_reg == hnbt_pkg::CLK_RDAT_HI) rd_byte[7:4] <= bus.nibble_bus;
        if (clk_reg == hnbt_pkg::CLK_LAST) begin            // RULE_14
          clk_reg <= 5'h00;
          busy    <= 1'b0;
          done    <= 1'b1;
          oe_reg  <= 1'b0;
        end else begin
          clk_reg <= nxt;
        end
      end
    end
  end

  assign bus.frame_strobe_n  = frame_reg;
  assign bus.host_nibble_out = out_reg;
  assign bus.host_nibble_oe  = oe_reg;
endmodule

// [testbench/hnbt_monitor.sv]
// Purpose: protocol watch on the nibble bus between host and target
// Assumes: one mclk domain, reset_n async low
// Notes:   at each edge cnt_reg is the number of the previous clock
`timescale 1ns/10ps
module hnbt_monitor (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // bus signals
  input wire logic       frame_strobe_n,
  input wire logic [3:0] host_nibble_out,
  input wire logic       host_nibble_oe,
  input wire logic [3:0] targ_nibble_out,
  input wire logic       targ_nibble_oe,
  input wire logic [3:0] nibble_bus
);
  // ==========================================================
  // cycle position; a start when idle, in clock 2 or right after clock 17
  logic [4:0] cnt_reg;
  logic       wr_reg;
  wire        is_start = nibble_bus == hnbt_pkg::START_READ
                         || nibble_bus == hnbt_pkg::START_WRITE;
  wire        restart  = !frame_strobe_n && is_start && (cnt_reg < 5'h02 || cnt_reg > 5'h10);
  wire  [4:0] cnt_next = restart ? 5'h01 :
                         (cnt_reg != 5'h00 && cnt_reg < 5'h11) ? cnt_reg + 5'h01 : 5'h00;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 5'h00;
      wr_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      wr_reg  <= restart ? (nibble_bus == hnbt_pkg::START_WRITE) : wr_reg;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_no_clash;
    !(host_nibble_oe && targ_nibble_oe);
  endproperty
  property p_start_code;
    $fell(frame_strobe_n) |-> host_nibble_oe && is_start;
  endproperty
  property p_size;
    cnt_reg == 5'h09 |-> host_nibble_oe && host_nibble_out == hnbt_pkg::SIZE_ONE;
  endproperty
  property p_target_quiet;
    (cnt_reg < 5'h0b || (wr_reg && cnt_reg < 5'h0d) || cnt_reg > 5'h0f) |-> !targ_nibble_oe;
  endproperty
  property p_host_tar_read;
    !wr_reg && cnt_reg == 5'h0a |-> host_nibble_oe && host_nibble_out == hnbt_pkg::TAR_ONES
      ##1 !host_nibble_oe [*6];
  endproperty
  property p_host_tar_write;
    wr_reg && cnt_reg == 5'h0c |-> host_nibble_out == hnbt_pkg::TAR_ONES ##1 !host_nibble_oe [*4];
  endproperty
  property p_read_answer;
    !wr_reg && cnt_reg == 5'h0b && targ_nibble_oe |-> nibble_bus == hnbt_pkg::TAR_ONES
      ##1 targ_nibble_oe && nibble_bus == hnbt_pkg::SYNC_READY ##1 targ_nibble_oe [*2]
      ##1 targ_nibble_oe && nibble_bus == hnbt_pkg::TAR_ONES ##1 !targ_nibble_oe;
  endproperty
  property p_write_answer;
    wr_reg && cnt_reg == 5'h0d && targ_nibble_oe |-> nibble_bus == hnbt_pkg::TAR_ONES
      ##1 targ_nibble_oe && targ_nibble_out == hnbt_pkg::SYNC_READY
      ##1 targ_nibble_oe && nibble_bus == hnbt_pkg::TAR_ONES ##1 !targ_nibble_oe;
  endproperty
  property p_miss_silent;
    !wr_reg && cnt_reg == 5'h0b && !targ_nibble_oe |-> !targ_nibble_oe [*5];
  endproperty
  a_no_clash:       assert property (p_no_clash) else $error("both ends drive the bus");
  a_start_code:     assert property (p_start_code) else $error("strobe low without start");
  a_size:           assert property (p_size) else $error("size nibble not one byte");
  a_target_quiet:   assert property (p_target_quiet) else $error("target drives too early");
  a_host_tar_read:  assert property (p_host_tar_read) else $error("host read turnaround bad");
  a_host_tar_write: assert property (p_host_tar_write) else $error("host write turnaround bad");
  a_read_answer:    assert property (p_read_answer) else $error("read answer fields bad");
  a_write_answer:   assert property (p_write_answer) else $error("write sync fields bad");
  a_miss_silent:    assert property (p_miss_silent) else $error("unselected target drives");
  c_read:  cover property (!wr_reg && cnt_reg == 5'h0c && targ_nibble_oe);
  c_write: cover property (wr_reg && cnt_reg == 5'h0e && targ_nibble_oe);
  c_miss:  cover property (cnt_reg == 5'h0c && !targ_nibble_oe);
endmodule

// [testbench/testbench.sv]
// Purpose: table of host cycles plus fault cases on a second target
// Assumes: strap 5 on both targets; second bus driven by hand
// Notes:   select values d and e are avoided, they equal the two start codes
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic        w;
    logic [3:0]  tgt;
    logic [27:0] addr;
    logic [7:0]  dat;
  } hnbt_row_t;
  logic        mclk = 1'b0, reset_n = 1'b0, req = 1'b0, req_write = 1'b0, op_busy = 1'b0;
  logic [3:0]  strap = 4'h5, req_target = 4'h0;
  logic [27:0] req_addr = 28'h0;
  logic [7:0]  req_wdata = 8'h00, rd_data = 8'h00, rd_byte, wr_data, wr_data2, wd, wd2;
  logic [19:0] mem_addr, ma;
  logic        busy, done, sync_ok, standby, ready, rd_req, wr_strobe, space_sel, ss;
  logic        standby2, ready2, wr2;
  int          fails = 0, compares = 0, wr_n = 0, rd_n = 0, wr2_n = 0, oe2_n = 0;
  hnbt_row_t   rows [6] = '{'{1'b1, 4'h5, 28'hff45a3c, 8'h96}, '{1'b0, 4'h5, 28'hff45a3c, 8'h3c},
                            '{1'b0, 4'h5, 28'hfffffff, 8'ha5}, '{1'b1, 4'h5, 28'h0000000, 8'h01},
                            '{1'b1, 4'h0, 28'h1234567, 8'h77}, '{1'b0, 4'hf, 28'hff80000, 8'h88}};
  hnbt_if bus_if();
  hnbt_if bus_if2();
  hnbt_host hnbt_host_i (.mclk, .reset_n, .bus(bus_if.host), .req, .req_write, .req_target,
    .req_addr, .req_wdata, .busy, .done, .sync_ok, .rd_byte);
  hnbt_target hnbt_target_i (.mclk, .reset_n, .bus(bus_if.target), .identity_strap_pins(strap),
    .rd_data, .op_busy, .standby, .ready, .rd_req, .wr_strobe, .space_sel, .mem_addr, .wr_data);
  // second target faces the bench, which breaks the host's rules on purpose
  hnbt_target hnbt_target_i2 (.mclk, .reset_n, .bus(bus_if2.target), .identity_strap_pins(strap),
    .rd_data(8'h00), .op_busy(1'b0), .standby(standby2), .ready(ready2), .rd_req(),
    .wr_strobe(wr2), .space_sel(), .mem_addr(), .wr_data(wr_data2));
  hnbt_monitor hnbt_monitor_i (.mclk, .reset_n, .frame_strobe_n(bus_if.frame_strobe_n),
    .host_nibble_out(bus_if.host_nibble_out), .host_nibble_oe(bus_if.host_nibble_oe),
    .targ_nibble_out(bus_if.targ_nibble_out), .targ_nibble_oe(bus_if.targ_nibble_oe),
    .nibble_bus(bus_if.nibble_bus));
  // ==========================================================
  // clock and capture of the memory-side pulses
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (wr_strobe === 1'b1) begin
      wr_n++;
      wd = wr_data;
      ma = mem_addr;
      ss = space_sel;
    end
    if (rd_req === 1'b1) begin
      rd_n++;
      ma = mem_addr;
      ss = space_sel;
    end
    if (wr2 === 1'b1) begin
      wr2_n++;
      wd2 = wr_data2;
    end
    if (bus_if2.targ_nibble_oe === 1'b1) oe2_n++;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one host request, called just after a falling edge
  task automatic hcyc(input hnbt_row_t r);
    int n;
    int w0;
    int r0;
    n = 0;
    w0 = wr_n;
    r0 = rd_n;
    {req_write, req_target, req_addr, req_wdata} = r;
    rd_data = r.dat;
    req = 1'b1;
    // let one edge pass first: the done pulse of the previous cycle may still stand
    do begin
      @(negedge mclk);
      n++;
      if (busy === 1'b1) req = 1'b0;
    end while (done !== 1'b1 && n < 40);
    chk("done", n < 40, 1'b1);
    chk("sync_ok", sync_ok, r.tgt == strap);
    chk("writes", wr_n - w0, r.w && r.tgt == strap);
    chk("reads", rd_n - r0, !r.w && r.tgt == strap);
    if (r.tgt == strap) begin
      chk("addr", ma, r.addr[19:0]);
      chk("space", ss, r.addr[hnbt_pkg::SPACE_BIT]);
      chk("data", r.w ? wd : rd_byte, r.dat);
    end
  endtask
  task automatic drv(input logic s, input logic [3:0] nb);
    @(negedge mclk);
    bus_if2.frame_strobe_n = s;
    bus_if2.host_nibble_out = nb;
    bus_if2.host_nibble_oe = 1'b1;
  endtask
  // whole write on the second bus, optionally behind a read start
  task automatic raw_wr(input logic pre, input logic [3:0] sz, input logic [7:0] d);
    if (pre) drv(1'b0, hnbt_pkg::START_READ);
    drv(1'b0, hnbt_pkg::START_WRITE);
    drv(1'b1, strap);
    for (int i = 6; i >= 0; i--) drv(1'b1, 4'(i));
    drv(1'b1, sz);
    drv(1'b1, d[3:0]);
    drv(1'b1, d[7:4]);
    drv(1'b1, hnbt_pkg::TAR_ONES);
    @(negedge mclk);
    bus_if2.host_nibble_oe = 1'b0;
    repeat (6) @(negedge mclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int w;
    int o;
    bus_if2.frame_strobe_n = 1'b1;
    bus_if2.host_nibble_out = 4'hf;
    bus_if2.host_nibble_oe = 1'b0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    chk("standby", standby, 1'b1);
    foreach (rows[i]) hcyc(rows[i]);
    $display("test table done");
    op_busy = 1'b1;
    repeat (2) @(negedge mclk);
    chk("standby busy", standby, 1'b0);
    op_busy = 1'b0;
    drv(1'b0, 4'h3);
    drv(1'b0, 4'h3);
    chk("ready", ready2, 1'b1);
    drv(1'b1, 4'hf);
    // foreign select: the target drops the cycle and goes to standby at once
    drv(1'b0, hnbt_pkg::START_WRITE);
    drv(1'b1, 4'h0);
    drv(1'b1, 4'h1);
    chk("miss standby", standby2, 1'b1);
    $display("test modes done");
    w = wr2_n;
    o = oe2_n;
    raw_wr(1'b0, 4'h1, 8'h5a);
    chk("bad size drive", oe2_n - o, 0);
    raw_wr(1'b1, hnbt_pkg::SIZE_ONE, 8'hc3);
    chk("last start", wr2_n - w, 1);
    chk("last data", wd2, 8'hc3);
    chk("sync clocks", oe2_n - o, 3);
    drv(1'b0, hnbt_pkg::START_WRITE);
    drv(1'b1, strap);
    drv(1'b0, 4'h3);
    drv(1'b1, hnbt_pkg::ABORT_CODE);
    raw_wr(1'b0, hnbt_pkg::SIZE_ONE, 8'h69);
    chk("after abort", wr2_n - w, 2);
    chk("abort data", wd2, 8'h69);
    $display("test faults done");
    {req_write, req_target, req} = {1'b0, strap, 1'b1};
    repeat (8) @(negedge mclk);
    {reset_n, req} = 2'b00;
    @(negedge mclk);
    chk("rst strobe", bus_if.frame_strobe_n, 1'b1);
    chk("rst drive", bus_if.targ_nibble_oe, 1'b0);
    chk("rst busy", busy, 1'b0);
    reset_n = 1'b1;
    hcyc(rows[1]);
    $display("test reset done");
    close_out();
  end
  // watchdog, about fifty times the expected run
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule
